// *** common/gate_protect_defines.vh ***
// Purpose: constants of the three-phase gate protection block
// Assumes: 100 MHz design clock, AXI4-Lite register access
// Notes:   times are in microseconds, counts derived in the module
`ifndef GATE_PROTECT_DEFINES_VH
`define GATE_PROTECT_DEFINES_VH

// register byte addresses
`define REG_CTRL_ADDR   4'h0
`define REG_STAT_ADDR   4'h4
// control fields
`define CTRL_EN_BIT     0
`define CTRL_RESET      1'h1
// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// timing, microseconds
`define TRIP_HOLD_US    2000
`define FLT_CLR_US      1900
`define CLK_MHZ         100

`endif

// *** dv/gate_cmd_source.sv ***
// Purpose: controller model driving the six gate commands
// Assumes: pin level low means a fault is seen
// Notes: ign_fault keeps commands up when a scenario asks for it
module gate_cmd_source #(parameter int DT = 2) (
    input logic aclk, pin, ign_fault,
    input logic [5:0] req,
    output logic [5:0] cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    int dt_r = 0;
    initial cmd = 6'h00;
    always @(posedge aclk) begin
        if (!pin && !ign_fault) begin
            cmd <= 6'h00;
            dt_r <= 0;
        end else if (cmd != req && dt_r < DT) begin
            cmd <= cmd & req;
            dt_r <= dt_r + 1;
        end else begin
            cmd <= req;
            dt_r <= 0;
        end
    end
endmodule // gate_cmd_source

// *** dv/gate_protect_asserts.sv ***
// Purpose: port checks of the gate protection block
// Assumes: commands and trip lag 3 edges, supplies and pin 1 edge
// Notes: bound to the block after endmodule
module gate_protect_asserts #(
    parameter int TRIP_HOLD_CYC = 20,
    parameter int FLT_CLR_CYC = 19
) (
    input logic aclk, aresetn, trip_sense_level, main_supply_ok,
    input logic lower_supply_ok, enable_fault_pin_i, enable_fault_pin_oe_n,
    input logic upper_float_supply_u_ok, upper_float_supply_v_ok,
    input logic upper_float_supply_w_ok, upper_gate_cmd_u, lower_gate_cmd_u,
    input logic upper_sw_u, upper_sw_v, upper_sw_w,
    input logic lower_sw_u, lower_sw_v, lower_sw_w, enable_fault_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire [2:0] up = {upper_sw_w, upper_sw_v, upper_sw_u};
    wire [2:0] lo = {lower_sw_w, lower_sw_v, lower_sw_u};
    wire [2:0] sok = {upper_float_supply_w_ok, upper_float_supply_v_ok,
                      upper_float_supply_u_ok};
    logic [2:0] tq_r;
    int since_r;
    // cycles since the resynced trip was last high
    always @(posedge aclk) begin
        tq_r <= {tq_r[1:0], trip_sense_level};
        if (!aresetn)
            since_r <= 1000;
        else if (tq_r[2])
            since_r <= 0;
        else if (since_r < 1000)
            since_r <= since_r + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    chk_upper_decode: assert property (
        upper_sw_u |-> $past(upper_gate_cmd_u, 3) && !$past(lower_gate_cmd_u, 3))
        else $error("upper on without its command");
    chk_trip_off: assert property (
        $past(trip_sense_level, 3) |-> !(up | lo)) else $error("trip not off");
    chk_trip_hold: assert property (
        |(up | lo) |-> since_r >= TRIP_HOLD_CYC) else $error("hold too short");
    chk_pin_off: assert property (
        !$past(enable_fault_pin_i) |-> !(up | lo)) else $error("pin low, on");
    chk_lower_uv: assert property (
        !$past(lower_supply_ok) |-> lo == 3'h0) else $error("lower uv, on");
    chk_main_uv: assert property (
        !$past(main_supply_ok) |-> !(up | lo)) else $error("main uv, on");
    chk_upper_uv: assert property (
        (up & ~$past(sok)) == 3'h0) else $error("upper uv, on");
    chk_trip_flag: assert property (
        $past(trip_sense_level, 3) |-> !enable_fault_pin_oe_n)
        else $error("trip not flagged");
    chk_flag_hold: assert property (
        $rose(enable_fault_pin_oe_n) |-> since_r >= FLT_CLR_CYC - 2)
        else $error("flag released early");
    chk_pin_open_drain: assert property (
        !enable_fault_pin_o) else $error("pin driven high");
    cover property (|up);
    cover property ($past(trip_sense_level, 3));
    cover property (!enable_fault_pin_i);
endmodule // gate_protect_asserts

bind three_phase_gate_protect_logic gate_protect_asserts #(
    .TRIP_HOLD_CYC(TRIP_HOLD_CYC), .FLT_CLR_CYC(FLT_CLR_CYC)) u_chk (.*);

// *** dv/three_phase_gate_protect_logic_bench.sv ***
// Purpose: self-checking bench of the gate protection block
// Assumes: hold and release counts cut to 20 and 19 cycles
// Notes: outputs are read back through the status word
module three_phase_gate_protect_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 20;
    localparam int CLR = 19;
    logic aclk = 0, aresetn = 0, ext_low = 0, raw = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic trip_sense_level = 0, main_supply_ok = 1, lower_supply_ok = 1;
    logic upper_float_supply_u_ok = 1, upper_float_supply_v_ok = 1;
    logic upper_float_supply_w_ok = 1, enable_fault_pin_o;
    logic upper_sw_u, upper_sw_v, upper_sw_w, enable_fault_pin_oe_n;
    logic lower_sw_u, lower_sw_v, lower_sw_w;
    logic upper_gate_cmd_u, upper_gate_cmd_v, upper_gate_cmd_w;
    logic lower_gate_cmd_u, lower_gate_cmd_v, lower_gate_cmd_w;
    logic [5:0] req = 0;
    logic [7:0] r = 8'h14;
    logic [31:0] eq[$], mq[$];
    int bad_count = 0, samples_checked = 0, cyc = 0;
    // pulled-up pin, low when either side pulls
    wire enable_fault_pin_i = !ext_low &&
        (enable_fault_pin_oe_n || enable_fault_pin_o);
    always #5 aclk = ~aclk;
    three_phase_gate_protect_logic #(.TRIP_HOLD_CYC(HOLD), .FLT_CLR_CYC(CLR))
        u_three_phase_gate_protect_logic (.*);
    gate_cmd_source u_gate_cmd_source (.aclk(aclk), .pin(enable_fault_pin_i),
        .ign_fault(raw), .req(req), .cmd({lower_gate_cmd_w, lower_gate_cmd_v,
        lower_gate_cmd_u, upper_gate_cmd_w, upper_gate_cmd_v, upper_gate_cmd_u}));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, e);
        logic aw, w;
        eq.push_back(e);
        mq.push_back(3);
        @(posedge aclk);
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (aw || w) begin
            @(posedge aclk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
        eq.push_back(e);
        mq.push_back(m);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    // settle past resync and dead time, then read the status word
    task automatic look(input logic [5:0] o, input logic drv);
        repeat (8) @(posedge aclk);
        rd(4'h4, {o, 6'h0, drv, 3'h0}, 32'h0000_FC08);
    endtask
    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
            chk((s_axi_bvalid ? {30'h0, s_axi_bresp} : s_axi_rdata)
                & mq.pop_front(), eq.pop_front());
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            report_and_stop;
        end
    end
    initial begin
        logic [5:0] v;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rd(4'h0, 1, 1);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            v = {r[1:0], i[1], r[3:2], i[0]};
            req <= v;
            look({v[5:3] & ~v[2:0], v[2:0] & ~v[5:3]}, 0);
        end
        req <= 6'h07;
        wr(4'h0, 0, 0);
        look(0, 0);
        wr(4'h0, 1, 0);
        wr(4'h4, 0, 0);
        wr(4'h8, 1, 2);
        rd(4'h8, 0, 32'hFFFF_FFFF);
        raw <= 1;
        ext_low <= 1;
        look(0, 0);
        ext_low <= 0;
        trip_sense_level <= 1;
        look(0, 1);
        trip_sense_level <= 0;
        look(0, 1);
        repeat (HOLD) @(posedge aclk);
        look(6'h07, 0);
        main_supply_ok <= 0;
        look(0, 1);
        main_supply_ok <= 1;
        repeat (CLR) @(posedge aclk);
        look(6'h07, 0);
        req <= 6'h38;
        lower_supply_ok <= 0;
        look(0, 0);
        lower_supply_ok <= 1;
        look(6'h38, 0);
        req <= 6'h07;
        upper_float_supply_v_ok <= 0;
        look(6'h05, 0);
        upper_float_supply_v_ok <= 1;
        look(6'h05, 0);
        req <= 6'h05;
        look(6'h05, 0);
        req <= 6'h07;
        look(6'h07, 0);
        report_and_stop;
    end
endmodule // three_phase_gate_protect_logic_bench

// *** hdl/three_phase_gate_protect_logic.v ***
// Purpose: gate command decode and protection for a three-phase bridge
// Assumes: inputs synchronous to aclk except commands and trip (resynced)
// Notes:   enable/fault pin is open drain, driven low only
//
// Operation
// RULE_01: pin high, no trip: 1,0 upper on; 0,1 lower on; else both off.
// RULE_02: trip input asserted turns off all six switches regardless of commands.
// RULE_03: after trip clears, keep all off for 2 ms, then decode again.
// RULE_04: fault pin reports faults; external low holds every output off.
// RULE_05: upper supply undervoltage latches upper gate off until its command low.
// RULE_06: lower supply undervoltage turns lower gates off, auto release on recovery.
// RULE_07: main supply undervoltage turns all outputs off, resumes at once; code also pulls the fault pin low, so outputs stay off until the pin releases.
// RULE_08: one upper supply drop affects only that phase's upper output.
// RULE_09: controller inserts its own dead time between opposite switches.
// RULE_10: pull fault pin low during fault, release 1.9 ms after it clears.
// RULE_11: controller drives all gate commands low on seeing a fault.
// RULE_12: resync commands and trip; delays counted from clock frequency parameter.
`include "gate_protect_defines.vh"

module three_phase_gate_protect_logic #(
    parameter CLK_MHZ       = `CLK_MHZ,
    parameter TRIP_HOLD_CYC = `TRIP_HOLD_US * CLK_MHZ,
    parameter FLT_CLR_CYC   = `FLT_CLR_US * CLK_MHZ,
    parameter CNT_W         = 24
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // gate commands
    input  wire        upper_gate_cmd_u,
    input  wire        upper_gate_cmd_v,
    input  wire        upper_gate_cmd_w,
    input  wire        lower_gate_cmd_u,
    input  wire        lower_gate_cmd_v,
    input  wire        lower_gate_cmd_w,
    // protection inputs
    input  wire        trip_sense_level,
    input  wire        main_supply_ok,
    input  wire        lower_supply_ok,
    input  wire        upper_float_supply_u_ok,
    input  wire        upper_float_supply_v_ok,
    input  wire        upper_float_supply_w_ok,
    // enable/fault pin, open drain
    input  wire        enable_fault_pin_i,
    output wire        enable_fault_pin_o,
    output wire        enable_fault_pin_oe_n,
    // switch drives
    output wire        upper_sw_u,
    output wire        upper_sw_v,
    output wire        upper_sw_w,
    output wire        lower_sw_u,
    output wire        lower_sw_v,
    output wire        lower_sw_w
);

    ////////////////////////////////////////////////////////////////////
    // address decode
    function [1:0] reg_sel;
        input [3:0] addr;
        begin
            if (addr == `REG_CTRL_ADDR) begin
                reg_sel = 2'h1;
            end else if (addr == `REG_STAT_ADDR) begin
                reg_sel = 2'h2;
            end else begin
                reg_sel = 2'h0;
            end
        end
    endfunction

    reg              awready_r;
    reg              wready_r;
    reg              bvalid_r;
    reg  [1:0]       bresp_r;
    reg              arready_r;
    reg              rvalid_r;
    reg  [31:0]      rdata_r;
    reg  [1:0]       rresp_r;
    reg              aw_got_r;
    reg              w_got_r;
    reg  [3:0]       awaddr_r;
    reg  [31:0]      wdata_r;
    reg              wstrb0_r;
    reg              soft_en_r;
    reg  [5:0]       cmd_s1_r;
    reg  [5:0]       cmd_s2_r;
    reg              trip_s1_r;
    reg              trip_s2_r;
    reg  [CNT_W-1:0] trip_cnt_r;
    reg  [CNT_W-1:0] flt_cnt_r;
    reg  [2:0]       uv_latch_r;
    reg  [2:0]       upper_r;
    reg  [2:0]       lower_r;
    reg              pin_oe_n_r;
    reg              pin_o_r;
    reg  [31:0]      stat_w;

    wire [2:0] up_cmd    = cmd_s2_r[2:0];
    wire [2:0] lo_cmd    = cmd_s2_r[5:3];
    wire [2:0] float_ok  = {upper_float_supply_w_ok,
                            upper_float_supply_v_ok,
                            upper_float_supply_u_ok};
    wire       trip_blk  = trip_s2_r | (trip_cnt_r != {CNT_W{1'b0}});
    wire       fault_now = trip_s2_r | ~main_supply_ok;
    wire       pin_drv   = fault_now | (flt_cnt_r != {CNT_W{1'b0}});
    wire       run       = main_supply_ok & enable_fault_pin_i &
                           ~trip_blk & soft_en_r;

    ////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OKAY;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= 4'h0;
            wdata_r   <= 32'h0;
            wstrb0_r  <= 1'b0;
            soft_en_r <= `CTRL_RESET;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awaddr_r  <= s_axi_awaddr;
                aw_got_r  <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                wdata_r  <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
                w_got_r  <= 1'b1;
                wready_r <= 1'b0;
            end
            if (aw_got_r && w_got_r && !bvalid_r) begin
                bvalid_r <= 1'b1;
                if (reg_sel(awaddr_r) == 2'h1) begin
                    bresp_r <= `RESP_OKAY;
                    if (wstrb0_r) begin
                        soft_en_r <= wdata_r[`CTRL_EN_BIT];
                    end
                end else if (reg_sel(awaddr_r) == 2'h2) begin
                    bresp_r <= `RESP_OKAY;
                end else begin
                    bresp_r <= `RESP_SLVERR;
                end
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                aw_got_r  <= 1'b0;
                w_got_r   <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    always @* begin
        stat_w     = 32'h0;
        stat_w[0]  = soft_en_r;
        stat_w[1]  = trip_s2_r;
        stat_w[2]  = trip_blk;
        stat_w[3]  = ~pin_oe_n_r;
        stat_w[4]  = enable_fault_pin_i;
        stat_w[5]  = ~main_supply_ok;
        stat_w[6]  = ~lower_supply_ok;
        stat_w[9:7] = uv_latch_r;
        stat_w[12:10] = upper_r;
        stat_w[15:13] = lower_r;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0;
            rresp_r   <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                if (reg_sel(s_axi_araddr) == 2'h1) begin
                    rdata_r <= {31'h0, soft_en_r};
                    rresp_r <= `RESP_OKAY;
                end else if (reg_sel(s_axi_araddr) == 2'h2) begin
                    rdata_r <= stat_w;
                    rresp_r <= `RESP_OKAY;
                end else begin
                    rdata_r <= 32'h0;
                    rresp_r <= `RESP_SLVERR;
                end
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // input resync and fault timers
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_s1_r   <= 6'h0;
            cmd_s2_r   <= 6'h0;
            trip_s1_r  <= 1'b0;
            trip_s2_r  <= 1'b0;
            trip_cnt_r <= {CNT_W{1'b0}};
            flt_cnt_r  <= {CNT_W{1'b0}};
        end else begin
            cmd_s1_r  <= {lower_gate_cmd_w, lower_gate_cmd_v,
                          lower_gate_cmd_u, upper_gate_cmd_w,
                          upper_gate_cmd_v, upper_gate_cmd_u};  // [RULE_12]
            cmd_s2_r  <= cmd_s1_r;
            trip_s1_r <= trip_sense_level;                      // [RULE_12]
            trip_s2_r <= trip_s1_r;
            if (trip_s2_r) begin
                trip_cnt_r <= TRIP_HOLD_CYC[CNT_W-1:0];         // [RULE_03]
            end else if (trip_cnt_r != {CNT_W{1'b0}}) begin
                trip_cnt_r <= trip_cnt_r - 1'b1;
            end
            if (fault_now) begin
                flt_cnt_r <= FLT_CLR_CYC[CNT_W-1:0];            // [RULE_10]
            end else if (flt_cnt_r != {CNT_W{1'b0}}) begin
                flt_cnt_r <= flt_cnt_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-phase decode and undervoltage latches
    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            uv_latch_r <= 3'h0;
            upper_r    <= 3'h0;
            lower_r    <= 3'h0;
            pin_oe_n_r <= 1'b1;
            pin_o_r    <= 1'b0;
        end else begin
            pin_o_r    <= 1'b0;
            pin_oe_n_r <= ~pin_drv;                             // [RULE_04]
            for (i = 0; i < 3; i = i + 1) begin
                if (!float_ok[i]) begin
                    uv_latch_r[i] <= 1'b1;                      // [RULE_05]
                end else if (!up_cmd[i]) begin
                    uv_latch_r[i] <= 1'b0;                      // [RULE_05]
                end
                // run covers trip, hold, pin and main supply
                upper_r[i] <= run & up_cmd[i] & ~lo_cmd[i] &
                              float_ok[i] & ~uv_latch_r[i];     // [RULE_01] [RULE_02] [RULE_07] [RULE_08]
                lower_r[i] <= run & lo_cmd[i] & ~up_cmd[i] &
                              lower_supply_ok;                  // [RULE_01] [RULE_06] [RULE_04]
            end
        end
    end

    assign s_axi_awready         = awready_r;
    assign s_axi_wready          = wready_r;
    assign s_axi_bvalid          = bvalid_r;
    assign s_axi_bresp           = bresp_r;
    assign s_axi_arready         = arready_r;
    assign s_axi_rvalid          = rvalid_r;
    assign s_axi_rdata           = rdata_r;
    assign s_axi_rresp           = rresp_r;
    assign enable_fault_pin_o    = pin_o_r;
    assign enable_fault_pin_oe_n = pin_oe_n_r;
    assign upper_sw_u            = upper_r[0];
    assign upper_sw_v            = upper_r[1];
    assign upper_sw_w            = upper_r[2];
    assign lower_sw_u            = lower_r[0];
    assign lower_sw_v            = lower_r[1];
    assign lower_sw_w            = lower_r[2];

endmodule // three_phase_gate_protect_logic
